//--- cpid_pkg.sv
package cpid_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0]  CPID_OFS_HPEND     = 8'h18;
	localparam logic [7:0]  CPID_OFS_IDENT     = 8'hFC;
	localparam logic [7:0]  CPID_OFS_CTRL      = 8'h00;

	// ==========================================================
	// Field layout
	localparam int          CPID_ID_W          = 10;
	localparam int          CPID_CPU_W         = 3;
	localparam int          CPID_ID_LSB        = 0;
	localparam int          CPID_CPU_LSB       = 10;
	localparam int          CPID_PROD_LSB      = 20;
	localparam int          CPID_ARCH_LSB      = 16;
	localparam int          CPID_REV_LSB       = 12;
	localparam int          CPID_CONT_LSB      = 8;
	localparam int          CPID_CTRL_EN_BIT   = 0;
	localparam int          CPID_CTRL_ACK_BIT  = 2;

	// ==========================================================
	// Values
	localparam logic [9:0]  CPID_SPURIOUS_ID   = 10'h3FF;
	localparam logic [3:0]  CPID_ARCH_VERSION  = 4'h1;
	localparam logic [9:0]  CPID_SOFT_IRQ_LAST = 10'h00F;
	localparam logic [31:0] CPID_CTRL_RESET    = 32'h0000_0000;
	localparam logic [31:0] CPID_ZERO          = 32'h0000_0000;

endpackage : cpid_pkg

//--- cpid_ident_word.sv
`timescale 1ns/100ps
module cpid_ident_word
	import cpid_pkg::*;
#(
	parameter logic [11:0] PRODUCT_ID  = 12'h001, // Arbitrary value
	parameter logic [3:0]  REVISION    = 4'h0,
	parameter logic [3:0]  CONT_CODE   = 4'h0,    // Arbitrary value
	parameter logic [6:0]  IDENT_CODE  = 7'h01    // Arbitrary value
) (
	output wire logic [31:0] o_word
);
	// Bit 7 of the implementer field is forced to zero
	assign o_word = {PRODUCT_ID, CPID_ARCH_VERSION, REVISION,
			CONT_CODE, 1'b0, IDENT_CODE};
endmodule : cpid_ident_word

//--- cpid_readout.sv
`timescale 1ns/100ps
// Operation
// - Secure read, ack control set, Non-secure top pending: return its ID.
// - Secure top pending: ID to Secure reads, 1023 to Non-secure reads.
// - Nothing signalable pending or forwarding off: always return 1023.
// - Ident word: product in [31:20], revision in [15:12].
// - Ident word bits [19:16] read as architecture version 0x1.
// - Ident [11:0]: continuation [11:8], bit 7 zero, identity [6:0].
// - Ident register shared: Secure and Non-secure reads see same value.
// - Each interface instance has its own identification register.
// - Pending readout ID in bits [9:0], upper bits [31:13] reserved zero.
// - Bits [12:10] give requester number for software interrupt, multiprocessor.
module cpid_readout
	import cpid_pkg::*;
#(
	parameter bit          MULTI_PROC = 1'b1,
	parameter logic [11:0] PRODUCT_ID = 12'h001, // Arbitrary value
	parameter logic [3:0]  REVISION   = 4'h0
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_srst,
	input  wire logic [7:0]            i_addr,
	input  wire logic [31:0]           i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	input  wire logic                  i_secure,
	input  wire logic                  i_pend_valid,
	input  wire logic                  i_pend_secure,
	input  wire logic [CPID_ID_W-1:0]  i_pend_id,
	input  wire logic [CPID_CPU_W-1:0] i_pend_cpu,
	output logic      [31:0]           o_rdata,
	output logic                       o_fwd_enable,
	output logic                       o_ack_ctl
);
	// ==========================================================
	// Control register, Secure-only writes
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	wire         hit_ctrl  = i_addr == CPID_OFS_CTRL;
	wire         hit_hpend = i_addr == CPID_OFS_HPEND;
	wire         hit_ident = i_addr == CPID_OFS_IDENT;
	wire         ctrl_wr   = i_wr && hit_ctrl && i_secure;

	assign ctrl_next = ctrl_wr ?
		(i_wdata & ((32'h1 << CPID_CTRL_EN_BIT) |
			(32'h1 << CPID_CTRL_ACK_BIT))) : ctrl_reg;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ctrl_reg <= CPID_CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	assign o_fwd_enable = ctrl_reg[CPID_CTRL_EN_BIT];
	assign o_ack_ctl    = ctrl_reg[CPID_CTRL_ACK_BIT];

	// ==========================================================
	// Pending readout filter
	wire shown = i_pend_valid && o_fwd_enable &&
		(i_pend_secure ? i_secure
			: (!i_secure || o_ack_ctl));
	wire is_soft_irq = MULTI_PROC && (i_pend_id <= CPID_SOFT_IRQ_LAST);
	wire [CPID_ID_W-1:0]  out_id  = shown ? i_pend_id
		: CPID_SPURIOUS_ID;
	wire [CPID_CPU_W-1:0] out_cpu = (shown && is_soft_irq) ? i_pend_cpu
		: '0;
	wire [31:0] hpend_word = {19'h0, out_cpu, out_id};

	// ==========================================================
	// Identification, one copy per instance, not banked
	wire [31:0] ident_word;
	cpid_ident_word #(
		.PRODUCT_ID (PRODUCT_ID),
		.REVISION   (REVISION),
		.CONT_CODE  (4'h0),
		.IDENT_CODE (7'h01)
	) u_ident (
		.o_word (ident_word)
	);

	// ==========================================================
	// Read path; writes to read-only words fall through untouched
	logic [31:0] rdata_next;
	assign rdata_next = !i_rd ? CPID_ZERO :
		hit_hpend ? hpend_word :
		hit_ident ? ident_word :
		hit_ctrl  ? ctrl_reg : CPID_ZERO;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rdata <= CPID_ZERO;
		end else begin
			o_rdata <= rdata_next;
		end
	end

	// ==========================================================
	// Checks
	a_ns_secure_hide: assert property (
		@(posedge i_clk) disable iff (i_srst)
		i_rd && hit_hpend && !i_secure && i_pend_secure
		|=> o_rdata[9:0] == CPID_SPURIOUS_ID)
		else $error("secure pending leaked to non-secure read");
	a_ack_ctl_pass: assert property (
		@(posedge i_clk) disable iff (i_srst)
		i_rd && hit_hpend && i_secure && !i_pend_secure && i_pend_valid
		&& o_fwd_enable && o_ack_ctl
		|=> o_rdata[9:0] == $past(i_pend_id))
		else $error("non-secure id not given to secure read");
	// Ack control low hides Non-secure work from Secure software,
	// which then sees the one spurious code this block supports
	a_ack_ctl_block: assert property (
		@(posedge i_clk) disable iff (i_srst)
		i_rd && hit_hpend && i_secure && !i_pend_secure && !o_ack_ctl
		|=> o_rdata[9:0] == CPID_SPURIOUS_ID)
		else $error("non-secure id given without ack control");
	a_sec_own_id: assert property (
		@(posedge i_clk) disable iff (i_srst)
		i_rd && hit_hpend && i_secure && i_pend_secure && i_pend_valid
		&& o_fwd_enable |=> o_rdata[9:0] == $past(i_pend_id))
		else $error("secure id not returned");
	a_ns_own_id: assert property (
		@(posedge i_clk) disable iff (i_srst)
		i_rd && hit_hpend && !i_secure && !i_pend_secure && i_pend_valid
		&& o_fwd_enable |=> o_rdata[9:0] == $past(i_pend_id))
		else $error("non-secure id not returned");
	a_idle_spurious: assert property (
		@(posedge i_clk) disable iff (i_srst)
		i_rd && hit_hpend && (!i_pend_valid || !o_fwd_enable)
		|=> o_rdata == {22'h0, CPID_SPURIOUS_ID})
		else $error("spurious id expected");
	a_ident_fields: assert property (
		@(posedge i_clk) disable iff (i_srst)
		i_rd && hit_ident |=> o_rdata[19:16] == CPID_ARCH_VERSION
		&& !o_rdata[7] && o_rdata[31:20] == PRODUCT_ID)
		else $error("ident fields wrong");
	a_ident_rev: assert property (
		@(posedge i_clk) disable iff (i_srst)
		i_rd && hit_ident |=> o_rdata[15:12] == REVISION)
		else $error("ident revision wrong");
	a_ident_shared: assert property (
		@(posedge i_clk) disable iff (i_srst)
		i_rd && hit_ident ##1 i_rd && hit_ident
		|=> o_rdata == $past(o_rdata))
		else $error("ident differs between reads");
	a_hpend_upper: assert property (
		@(posedge i_clk) disable iff (i_srst)
		i_rd && hit_hpend |=> o_rdata[31:13] == 19'h0)
		else $error("reserved pending bits set");
	a_cpu_zero: assert property (
		@(posedge i_clk) disable iff (i_srst)
		i_rd && hit_hpend && i_pend_id > CPID_SOFT_IRQ_LAST
		|=> o_rdata[12:10] == 3'h0)
		else $error("cpu field set for non-software interrupt");
	a_cpu_given: assert property (
		@(posedge i_clk) disable iff (i_srst)
		i_rd && hit_hpend && MULTI_PROC && i_pend_valid && o_fwd_enable
		&& i_secure && i_pend_secure && i_pend_id <= CPID_SOFT_IRQ_LAST
		|=> o_rdata[12:10] == $past(i_pend_cpu))
		else $error("requester number missing");
	a_ro_write: assert property (
		@(posedge i_clk) disable iff (i_srst)
		i_wr && !hit_ctrl |=> $stable(ctrl_reg))
		else $error("write to read-only word changed state");
	// Only Secure software may open or close forwarding
	a_ns_ctrl_wr: assert property (
		@(posedge i_clk) disable iff (i_srst)
		i_wr && hit_ctrl && !i_secure |=> $stable(ctrl_reg))
		else $error("non-secure write changed control");
	a_ctrl_load: assert property (
		@(posedge i_clk) disable iff (i_srst)
		i_wr && hit_ctrl && i_secure
		|=> o_fwd_enable == $past(i_wdata[CPID_CTRL_EN_BIT])
		&& o_ack_ctl == $past(i_wdata[CPID_CTRL_ACK_BIT]))
		else $error("secure control write lost");
	// Read data stand one cycle only, so stale words never linger
	a_rdata_quiet: assert property (
		@(posedge i_clk) disable iff (i_srst)
		!i_rd |=> o_rdata == CPID_ZERO)
		else $error("read data without read");

	c_ns_read: cover property (@(posedge i_clk)
		i_rd && hit_hpend && !i_secure && !i_pend_secure && shown);
	c_sec_ack: cover property (@(posedge i_clk)
		i_rd && hit_hpend && i_secure && !i_pend_secure && shown);
	c_spur: cover property (@(posedge i_clk)
		i_rd && hit_hpend && !shown);
	c_ident: cover property (@(posedge i_clk) i_rd && hit_ident);
	c_ident_pair: cover property (@(posedge i_clk)
		i_rd && hit_ident ##1 i_rd && hit_ident);

endmodule : cpid_readout

//--- cpid_core_model.sv
`timescale 1ns/100ps
// ==========================================================
// Core side: one-cycle strobes except the two-cycle o_rd of rd_two, data taken in the cycle after
module cpid_core_model (
	input  wire logic        i_clk,
	input  wire logic [31:0] i_rdata,
	output logic      [7:0]  o_addr,
	output logic      [31:0] o_wdata,
	output logic             o_wr,
	output logic             o_rd,
	output logic             o_secure
);
	initial begin
		{o_addr, o_wdata, o_wr, o_rd, o_secure} = '0;
	end
	task automatic wr_word(input logic [7:0] a, input logic [31:0] d,
		input logic s);
		@(posedge i_clk);
		{o_addr, o_wdata, o_secure, o_wr} <= {a, d, s, 1'b1};
		@(posedge i_clk);
		o_wr <= 1'b0;
	endtask : wr_word
	// Data stands one cycle only, so it is taken just after that edge
	task automatic rd_word(input logic [7:0] a, input logic s,
		output logic [31:0] d);
		@(posedge i_clk);
		{o_addr, o_secure, o_rd} <= {a, s, 1'b1};
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1 d = i_rdata;
	endtask : rd_word
	// Two reads with no gap, Secure first and Non-secure second
	task automatic rd_two(input logic [7:0] a, output logic [31:0] d0,
		output logic [31:0] d1);
		@(posedge i_clk);
		{o_addr, o_secure, o_rd} <= {a, 1'b1, 1'b1};
		@(posedge i_clk);
		o_secure <= 1'b0;
		#1 d0 = i_rdata;
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1 d1 = i_rdata;
	endtask : rd_two
endmodule : cpid_core_model

//--- cpid_readout_bench.sv
`timescale 1ns/100ps
// ==========================================================
// Bench
module cpid_readout_bench;
	import cpid_pkg::*;
	localparam logic [31:0] EXP_ID = 32'hABC1_5001;
	logic        clk, srst, pv, ps, wr, rd, sec, fwd, ack;
	logic [9:0]  pid;
	logic [2:0]  pcpu;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, d;
	int          error_cnt, n_compared;
	cpid_core_model core (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
		.o_wdata(wdata), .o_wr(wr), .o_rd(rd), .o_secure(sec));
	cpid_readout #(.PRODUCT_ID(12'hABC), .REVISION(4'h5)) dut (.i_clk(clk),
		.i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.i_secure(sec), .i_pend_valid(pv), .i_pend_secure(ps),
		.i_pend_id(pid), .i_pend_cpu(pcpu), .o_rdata(rdata),
		.o_fwd_enable(fwd), .o_ack_ctl(ack));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// Ident is shared by both worlds and cannot be written
	task automatic t_ident;
		logic [31:0] d2;
		core.rd_two(CPID_OFS_IDENT, d, d2);
		chk("ident_pair_s", d, EXP_ID);
		chk("ident_pair_ns", d2, EXP_ID);
		core.rd_word(CPID_OFS_IDENT, 1'b1, d);
		chk("ident_s", d, EXP_ID);
		core.wr_word(CPID_OFS_IDENT, 32'hFFFF_FFFF, 1'b1);
		core.wr_word(CPID_OFS_CTRL, 32'h0000_0005, 1'b0);
		core.rd_word(CPID_OFS_IDENT, 1'b0, d);
		chk("ident_ns", d, EXP_ID);
		chk("ns_ctrl", {30'h0, fwd, ack}, 32'h0);
		core.rd_word(8'h40, 1'b1, d);
		chk("unmapped", d, 32'h0);
	endtask : t_ident
	// Every mix of pending world, access world, ack bit, enable, valid
	task automatic t_pend;
		logic        show;
		logic [31:0] e;
		for (int i = 0; i < 32; i++) begin
			core.wr_word(CPID_OFS_CTRL, {29'h0, i[2], 1'b0, i[3]}, 1'b1);
			{pv, ps} <= {i[4], i[0]};
			pid <= i[0] ? 10'h007 : 10'h2A5;
			core.rd_word(CPID_OFS_HPEND, i[1], d);
			chk("ctrl", {30'h0, fwd, ack}, {30'h0, i[3], i[2]});
			show = i[4] && i[3] && (i[0] ? i[1] : (!i[1] || i[2]));
			e = show ? {19'h0, i[0] ? 3'h6 : 3'h0, pid} : 32'h0000_03FF;
			chk("pending", d, e);
		end
		core.wr_word(CPID_OFS_HPEND, 32'h0000_0000, 1'b1);
		core.rd_word(CPID_OFS_HPEND, 1'b1, d);
		chk("pend_wr", d, {19'h0, 3'h6, 10'h007});
	endtask : t_pend
	initial begin
		{error_cnt, n_compared} = '0;
		{srst, pv, ps, pid, pcpu} = {1'b1, 1'b0, 1'b0, 10'h0, 3'h6};
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1 chk("reset", rdata, 32'h0);
		chk("reset_ctl", {30'h0, fwd, ack}, 32'h0);
		t_ident();
		t_pend();
		tally_and_finish();
	end
	initial begin
		#20000;
		error_cnt++;
		tally_and_finish();
	end
endmodule : cpid_readout_bench
